// ---- hw/ssq_pkg.sv ----
package ssq_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 8;
  localparam int TICK_MS = 100;
  localparam int TICK_CYC = TICK_MS * 1000000 / CLK_NS;
  localparam int MAN_TMO_MIN = 10;
  localparam logic [12:0] MAN_TMO = 13'(MAN_TMO_MIN * 60 * 1000 / TICK_MS);

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int NSTREAM = 6;
  localparam int DW = 16;
  localparam int AW = 7;
  localparam int SUM_W = 23;
  localparam int RAM_DEPTH = 128;

  // ----------------------------------------------------------------
  // settings: defaults and limits (times in 0.1 s)
  // ----------------------------------------------------------------
  localparam logic [12:0] PURGE_DEF = 13'h012c;
  localparam logic [12:0] PURGE_MAX = 13'h01c2;
  localparam logic [12:0] VISIT_MIN = 13'h0258;
  localparam logic [12:0] VISIT_MAX = 13'h0e10;
  localparam logic [12:0] VISIT_DEF = 13'h0258;
  localparam logic [6:0] AVG_MIN = 7'h01;
  localparam logic [6:0] AVG_MAX = 7'h64;
  localparam logic [6:0] AVG_DEF = 7'h0a;
  localparam logic [2:0] TOTAL_DEF = 3'h1;
  localparam logic [9:0] FLOW_MIN = 10'h2bc;
  localparam logic [9:0] FLOW_MAX = 10'h384;
  localparam logic [9:0] FLOW_DEF = 10'h320;
  localparam logic [5:0] ACTIVE_DEF = 6'h3f;
  localparam logic HOLD_EN_DEF = 1'b1;
  localparam logic DEEN_DEF = 1'b0;

  // ----------------------------------------------------------------
  // setting selectors
  // ----------------------------------------------------------------
  localparam logic [3:0] SEL_AVG = 4'h0;
  localparam logic [3:0] SEL_DEEN = 4'h1;
  localparam logic [3:0] SEL_TOTAL = 4'h2;
  localparam logic [3:0] SEL_FLOW = 4'h3;
  localparam logic [3:0] SEL_PURGE = 4'h4;
  localparam logic [3:0] SEL_HOLD = 4'h5;
  localparam logic [3:0] SEL_VISIT = 4'h6;
  localparam logic [3:0] SEL_ACTIVE = 4'h7;

  typedef enum logic {MD_AUTO = 1'b0, MD_MANUAL = 1'b1} ssq_mode_t;
  typedef enum logic {PH_DWELL = 1'b0, PH_MEAS = 1'b1} ssq_phase_t;

endpackage

// ---- hw/ssq_ram.sv ----
`timescale 1ns/100ps
`default_nettype none
module ssq_ram (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [ssq_pkg::AW-1:0] wr_addr,
  input wire logic [ssq_pkg::DW-1:0] wr_data,
  input wire logic [ssq_pkg::AW-1:0] rd_addr,
  output logic [ssq_pkg::DW-1:0] rd_data
);

  logic [ssq_pkg::DW-1:0] mem [ssq_pkg::RAM_DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule
`default_nettype wire

// ---- hw/ssq_sequencer.sv ----
`timescale 1ns/100ps
`default_nettype none
// How it works
// R01 - two modes, automatic and manual; automatic after reset
// R02 - automatic mode cycles through active streams, skipping inactive ones
// R03 - the selected stream's manifold valve is energized
// R04 - each stream switch starts a purge dwell, readings ignored
// R05 - during dwell the output holds that stream's last reported value
// R06 - dwell counts inside the visit; next stream after visit time
// R07 - purge hold settable 0.0 to 45.0 s, default 30.0 s
// R08 - in manual mode up or down steps to the next stream
// R09 - manual returns to auto after 10 min if enabled; back exits
// R10 - manual timeout enable defaults on; off keeps manual indefinitely
// R11 - boxcar average of 1 to 100 samples, default 10
// R12 - fail-safe polarity: energized normally, de-energized on fault; default off
// R13 - stream count accepts only 1, 3 or 6; default 1
// R14 - average length and stream count apply only after reboot
// R15 - flow target 700 to 900 cc/min, default 800
// R16 - setup values survive reboot and are offered for persistent storage
// R17 - factory restore waits for enter to proceed or back to abort
// R18 - per-stream visit time 60.0 to 360.0 s, default 60.0 s
// R19 - per-stream active flag, default on
// R20 - with no active stream, auto mode stays on the current stream
module ssq_sequencer #(
  parameter int TICK_CYC = ssq_pkg::TICK_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic manual_req,
  input wire logic key_up,
  input wire logic key_down,
  input wire logic key_back,
  input wire logic key_enter,
  input wire logic fac_req,
  input wire logic reboot,
  input wire logic fault,
  input wire logic smp_valid,
  input wire logic [15:0] smp_data,
  input wire logic set_wr,
  input wire logic [3:0] set_sel,
  input wire logic [2:0] set_ch,
  input wire logic [15:0] set_val,
  output logic [5:0] valve_on,
  output logic [2:0] stream,
  output logic manual_mode,
  output logic dwell,
  output logic [15:0] conc,
  output logic conc_upd,
  output logic relay_on,
  output logic [9:0] flow_target,
  output logic fac_pending,
  output logic fac_done,
  output logic set_ack,
  output logic set_err,
  output logic nv_save
);

  typedef struct packed {
    ssq_pkg::ssq_mode_t mode;
    ssq_pkg::ssq_phase_t phase;
    logic [2:0] stream;
    logic [5:0] valve;
    logic [23:0] tick_cnt;
    logic [12:0] ph_cnt;
    logic [12:0] man_cnt;
    logic [6:0] avg_len_pend;
    logic [6:0] avg_len;
    logic [2:0] total_pend;
    logic [2:0] total;
    logic deen;
    logic [9:0] flow;
    logic [12:0] purge;
    logic hold_en;
    logic [5:0][12:0] visit;
    logic [5:0] active;
    logic [5:0][15:0] held;
    logic [15:0] conc;
    logic conc_upd;
    logic avg_stage;
    logic avg_go;
    logic [15:0] new_smp;
    logic [6:0] wr_ptr;
    logic [6:0] fill;
    logic [22:0] sum;
    logic relay;
    logic fac_pend;
    logic fac_done;
    logic set_ack;
    logic set_err;
    logic nv_save;
  } ssq_state_t;

  ssq_state_t s_ff;
  ssq_state_t nxt_s;
  logic [15:0] old_smp;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [2:0] next_active(input logic [2:0] cur,
      input logic [2:0] tot, input logic [5:0] act);
    logic [2:0] pick;
    logic found;
    int idx;
    pick = cur;
    found = 1'b0;
    for (int k = 1; k <= ssq_pkg::NSTREAM; k++) begin
      idx = (int'(cur) + k) % int'(tot);
      if (!found && k <= int'(tot) && act[idx]) begin
        pick = 3'(idx);
        found = 1'b1;
      end
    end
    return pick;
  endfunction

  function automatic ssq_state_t defaults_all(input ssq_state_t st);
    ssq_state_t r;
    r = st;
    r.avg_len_pend = ssq_pkg::AVG_DEF;
    r.total_pend = ssq_pkg::TOTAL_DEF;
    r.deen = ssq_pkg::DEEN_DEF;
    r.flow = ssq_pkg::FLOW_DEF;
    r.purge = ssq_pkg::PURGE_DEF;
    r.hold_en = ssq_pkg::HOLD_EN_DEF;
    r.active = ssq_pkg::ACTIVE_DEF;
    for (int i = 0; i < ssq_pkg::NSTREAM; i++) begin
      r.visit[i] = ssq_pkg::VISIT_DEF;
    end
    return r;
  endfunction

  function automatic ssq_state_t switch_to(input ssq_state_t st,
      input logic [2:0] tgt);
    ssq_state_t r;
    r = st;
    r.stream = tgt;
    r.valve = 6'h01 << tgt; // [R03]
    r.ph_cnt = 13'h0000;
    r.phase = (st.purge == 13'h0000) ? ssq_pkg::PH_MEAS
                                     : ssq_pkg::PH_DWELL; // [R04]
    r.conc = st.held[tgt]; // [R05]
    r.conc_upd = 1'b0;
    r.avg_stage = 1'b0;
    r.avg_go = 1'b0;
    r.wr_ptr = 7'h00;
    r.fill = 7'h00;
    r.sum = 23'h000000;
    return r;
  endfunction

  // ----------------------------------------------------------------
  // averaging memory
  // ----------------------------------------------------------------
  ssq_ram u_ram (
    .clk(clk),
    .wr_en(s_ff.avg_stage),
    .wr_addr(s_ff.wr_ptr),
    .wr_data(s_ff.new_smp),
    .rd_addr(s_ff.wr_ptr),
    .rd_data(old_smp)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic tick;
    logic [12:0] ph_n;
    logic [12:0] man_n;
    logic [22:0] quot;
    logic full;
    tick = 1'b0;
    ph_n = 13'h0000;
    man_n = 13'h0000;
    quot = 23'h000000;
    full = 1'b0;
    nxt_s = s_ff;
    nxt_s.conc_upd = 1'b0;
    nxt_s.fac_done = 1'b0;
    nxt_s.set_ack = 1'b0;
    nxt_s.set_err = 1'b0;
    nxt_s.nv_save = 1'b0;
    nxt_s.avg_stage = 1'b0;
    nxt_s.avg_go = 1'b0;

    // time base of 0.1 s
    if (s_ff.tick_cnt == 24'(TICK_CYC - 1)) begin
      nxt_s.tick_cnt = 24'h000000;
      tick = 1'b1;
    end else begin
      nxt_s.tick_cnt = s_ff.tick_cnt + 24'h000001;
    end

    // boxcar: take sample, then update sum, then divide
    if (smp_valid && s_ff.phase == ssq_pkg::PH_MEAS && !s_ff.avg_stage
        && !s_ff.avg_go) begin // [R04]
      nxt_s.new_smp = smp_data;
      nxt_s.avg_stage = 1'b1;
    end
    if (s_ff.avg_stage) begin
      full = (s_ff.fill == s_ff.avg_len);
      nxt_s.sum = s_ff.sum + {7'h00, s_ff.new_smp}
                  - (full ? {7'h00, old_smp} : 23'h000000); // [R11]
      nxt_s.fill = full ? s_ff.fill : s_ff.fill + 7'h01;
      nxt_s.wr_ptr = (s_ff.wr_ptr == s_ff.avg_len - 7'h01) ? 7'h00
                     : s_ff.wr_ptr + 7'h01;
      nxt_s.avg_go = 1'b1;
    end
    if (s_ff.avg_go && s_ff.fill != 7'h00) begin
      quot = s_ff.sum / {16'h0000, s_ff.fill}; // [R11]
      nxt_s.conc = quot[15:0];
      nxt_s.held[s_ff.stream] = quot[15:0];
      nxt_s.conc_upd = 1'b1;
    end

    // visit timing
    if (tick) begin
      ph_n = s_ff.ph_cnt + 13'h0001;
      nxt_s.ph_cnt = ph_n;
      if (ph_n >= s_ff.purge) begin
        nxt_s.phase = ssq_pkg::PH_MEAS; // [R04]
      end
      if (s_ff.mode == ssq_pkg::MD_AUTO
          && ph_n >= s_ff.visit[s_ff.stream]) begin
        nxt_s = switch_to(nxt_s, next_active(s_ff.stream, s_ff.total,
                                             s_ff.active)); // [R02] [R06] [R20]
      end
    end

    // mode control
    if (s_ff.mode == ssq_pkg::MD_AUTO) begin
      if (manual_req) begin
        nxt_s.mode = ssq_pkg::MD_MANUAL; // [R01]
        nxt_s.man_cnt = 13'h0000;
      end
    end else begin
      if (tick) begin
        man_n = s_ff.man_cnt + 13'h0001;
        nxt_s.man_cnt = man_n;
        if (s_ff.hold_en && man_n >= ssq_pkg::MAN_TMO) begin
          nxt_s.mode = ssq_pkg::MD_AUTO; // [R09] [R10]
        end
      end
      if (key_back && !s_ff.fac_pend) begin
        nxt_s.mode = ssq_pkg::MD_AUTO; // [R09]
      end else if (key_up || key_down) begin
        nxt_s.man_cnt = 13'h0000;
        nxt_s = switch_to(nxt_s, 3'((int'(s_ff.stream) + 1)
                                    % int'(s_ff.total))); // [R08]
      end
    end

    // setup writes, range checked
    if (set_wr) begin
      nxt_s.set_err = 1'b1;
      case (set_sel)
        ssq_pkg::SEL_AVG: begin
          if (set_val >= 16'(ssq_pkg::AVG_MIN)
              && set_val <= 16'(ssq_pkg::AVG_MAX)) begin
            nxt_s.avg_len_pend = set_val[6:0]; // [R11] [R14]
            nxt_s.set_err = 1'b0;
          end
        end
        ssq_pkg::SEL_DEEN: begin
          nxt_s.deen = set_val[0]; // [R12]
          nxt_s.set_err = 1'b0;
        end
        ssq_pkg::SEL_TOTAL: begin
          if (set_val == 16'h0001 || set_val == 16'h0003
              || set_val == 16'h0006) begin
            nxt_s.total_pend = set_val[2:0]; // [R13] [R14]
            nxt_s.set_err = 1'b0;
          end
        end
        ssq_pkg::SEL_FLOW: begin
          if (set_val >= 16'(ssq_pkg::FLOW_MIN)
              && set_val <= 16'(ssq_pkg::FLOW_MAX)) begin
            nxt_s.flow = set_val[9:0]; // [R15]
            nxt_s.set_err = 1'b0;
          end
        end
        ssq_pkg::SEL_PURGE: begin
          if (set_val <= 16'(ssq_pkg::PURGE_MAX)) begin
            nxt_s.purge = set_val[12:0]; // [R07]
            nxt_s.set_err = 1'b0;
          end
        end
        ssq_pkg::SEL_HOLD: begin
          nxt_s.hold_en = set_val[0]; // [R10]
          nxt_s.set_err = 1'b0;
        end
        ssq_pkg::SEL_VISIT: begin
          if (set_ch < 3'(ssq_pkg::NSTREAM)
              && set_val >= 16'(ssq_pkg::VISIT_MIN)
              && set_val <= 16'(ssq_pkg::VISIT_MAX)) begin
            nxt_s.visit[set_ch] = set_val[12:0]; // [R18]
            nxt_s.set_err = 1'b0;
          end
        end
        ssq_pkg::SEL_ACTIVE: begin
          if (set_ch < 3'(ssq_pkg::NSTREAM)) begin
            nxt_s.active[set_ch] = set_val[0]; // [R19]
            nxt_s.set_err = 1'b0;
          end
        end
        default: begin
          nxt_s.set_err = 1'b1;
        end
      endcase
      nxt_s.set_ack = !nxt_s.set_err;
      nxt_s.nv_save = !nxt_s.set_err; // [R16]
    end

    // factory restore with confirmation
    if (s_ff.fac_pend) begin
      if (key_enter) begin
        nxt_s = defaults_all(nxt_s); // [R17]
        nxt_s.fac_pend = 1'b0;
        nxt_s.fac_done = 1'b1;
        nxt_s.nv_save = 1'b1;
      end else if (key_back) begin
        nxt_s.fac_pend = 1'b0; // [R17]
      end
    end else if (fac_req) begin
      nxt_s.fac_pend = 1'b1;
    end

    // fail-safe relay polarity
    nxt_s.relay = s_ff.deen ? !fault : fault; // [R12]

    // reboot applies pending values, settings kept
    if (reboot) begin
      nxt_s.avg_len = s_ff.avg_len_pend; // [R14]
      nxt_s.total = s_ff.total_pend; // [R14] [R16]
      nxt_s.mode = ssq_pkg::MD_AUTO; // [R01]
      nxt_s = switch_to(nxt_s, next_active(s_ff.total_pend - 3'h1,
                                           s_ff.total_pend, s_ff.active));
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_ff <= '0;
      s_ff.mode <= ssq_pkg::MD_AUTO; // [R01]
      s_ff.phase <= ssq_pkg::PH_DWELL;
      s_ff.valve <= 6'h01;
      s_ff.avg_len_pend <= ssq_pkg::AVG_DEF;
      s_ff.avg_len <= ssq_pkg::AVG_DEF; // [R11]
      s_ff.total_pend <= ssq_pkg::TOTAL_DEF;
      s_ff.total <= ssq_pkg::TOTAL_DEF; // [R13]
      s_ff.deen <= ssq_pkg::DEEN_DEF;
      s_ff.flow <= ssq_pkg::FLOW_DEF; // [R15]
      s_ff.purge <= ssq_pkg::PURGE_DEF; // [R07]
      s_ff.hold_en <= ssq_pkg::HOLD_EN_DEF; // [R10]
      s_ff.visit <= {6{ssq_pkg::VISIT_DEF}}; // [R18]
      s_ff.active <= ssq_pkg::ACTIVE_DEF; // [R19]
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign valve_on = s_ff.valve;
  assign stream = s_ff.stream;
  assign manual_mode = s_ff.mode;
  assign dwell = (s_ff.phase == ssq_pkg::PH_DWELL);
  assign conc = s_ff.conc;
  assign conc_upd = s_ff.conc_upd;
  assign relay_on = s_ff.relay;
  assign flow_target = s_ff.flow;
  assign fac_pending = s_ff.fac_pend;
  assign fac_done = s_ff.fac_done;
  assign set_ack = s_ff.set_ack;
  assign set_err = s_ff.set_err;
  assign nv_save = s_ff.nv_save;

endmodule
`default_nettype wire

// ---- bench/ssq_sequencer_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
module ssq_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic manual_req,
  input wire logic key_back,
  input wire logic key_enter,
  input wire logic fac_req,
  input wire logic reboot,
  input wire logic smp_valid,
  input wire logic set_wr,
  input wire logic [3:0] set_sel,
  input wire logic [15:0] set_val,
  input wire logic [5:0] valve_on,
  input wire logic [2:0] stream,
  input wire logic manual_mode,
  input wire logic dwell,
  input wire logic [15:0] conc,
  input wire logic conc_upd,
  input wire logic [9:0] flow_target,
  input wire logic fac_pending,
  input wire logic fac_done,
  input wire logic set_ack,
  input wire logic set_err
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic flw;
  assign flw = set_wr && set_sel == ssq_pkg::SEL_FLOW;
  sequence arm_s;
    fac_req ##1 fac_pending;
  endsequence
  sequence done_s;
    key_enter ##1 (fac_done && !fac_pending);
  endsequence
  valve_map_a: assert property (
    valve_on == (6'h01 << stream)) else $error("valve not of stream");
  flow_set_a: assert property (
    flw && set_val >= 16'h02bc && set_val <= 16'h0384 |=>
    set_ack && flow_target == 10'($past(set_val)))
    else $error("flow write lost");
  flow_rng_a: assert property (
    flw && (set_val < 16'h02bc || set_val > 16'h0384) |=>
    set_err && $stable(flow_target)) else $error("bad flow taken");
  switch_dwell_a: assert property (
    $changed(stream) |-> dwell) else $error("switch without dwell");
  dwell_hold_a: assert property (
    dwell && $stable(stream) && !$rose(dwell) |-> $stable(conc))
    else $error("conc moved in dwell");
  avg_lat_a: assert property (
    conc_upd |-> $past(smp_valid, 3)) else $error("update without sample");
  man_enter_a: assert property (
    manual_req && !key_back && !reboot |=> manual_mode)
    else $error("manual not entered");
  back_exit_a: assert property (
    manual_mode && key_back && !fac_pending && !fac_req && !manual_req
    |=> !manual_mode) else $error("back kept manual");
  fac_arm_a: assert property (
    fac_req |-> arm_s) else $error("restore not pending");
  fac_done_a: assert property (
    fac_pending && key_enter && !key_back |-> done_s)
    else $error("restore not done");
endmodule
bind ssq_sequencer ssq_chk i_chk (.clk(clk), .rst_n(rst_n),
  .manual_req(manual_req), .key_back(key_back), .key_enter(key_enter),
  .fac_req(fac_req), .reboot(reboot), .smp_valid(smp_valid),
  .set_wr(set_wr), .set_sel(set_sel), .set_val(set_val),
  .valve_on(valve_on), .stream(stream), .manual_mode(manual_mode),
  .dwell(dwell), .conc(conc), .conc_upd(conc_upd),
  .flow_target(flow_target), .fac_pending(fac_pending),
  .fac_done(fac_done), .set_ack(set_ack), .set_err(set_err));
`default_nettype wire

// ---- bench/ssq_manifold.sv ----
`timescale 1ns/100ps
`default_nettype none
module ssq_manifold (
  input wire logic clk,
  input wire logic go,
  input wire logic dwell,
  output logic smp_valid,
  output logic [15:0] smp_data
);
  int seed = 24716;
  int gap = 0;
  initial begin
    smp_valid = 1'b0;
    smp_data = 16'h0000;
  end
  // one sample every 4 cycles; line toggles when idle
  always @(negedge clk) begin
    gap = (gap + 1) % 4;
    smp_valid <= go && !dwell && gap == 0;
    smp_data <= (go && gap == 0) ? 16'($random(seed)) : ~smp_data;
  end
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic manual_req = 1'b0, key_up = 1'b0, key_down = 1'b0;
  logic key_back = 1'b0, key_enter = 1'b0, fac_req = 1'b0;
  logic reboot = 1'b0, fault = 1'b0, set_wr = 1'b0, go = 1'b0;
  logic [3:0] set_sel = 4'h0;
  logic [2:0] set_ch = 3'h0;
  logic [15:0] set_val = 16'h0000;
  logic smp_valid, manual_mode, dwell, conc_upd, relay_on;
  logic fac_pending, fac_done, set_ack, set_err, nv_save;
  logic [15:0] smp_data, conc;
  logic [5:0] valve_on;
  logic [2:0] stream, pv_s = 3'h0;
  logic [9:0] flow_target;
  logic pv_d = 1'b1;
  int q[$];
  int last[6];
  int len = 10, err_total = 0, compares = 0, cyc = 0, t0, s;
  always #4 clk = ~clk;
  ssq_sequencer #(.TICK_CYC(5)) i_ssq_sequencer (.clk(clk),
    .rst_n(rst_n), .manual_req(manual_req), .key_up(key_up),
    .key_down(key_down), .key_back(key_back), .key_enter(key_enter),
    .fac_req(fac_req), .reboot(reboot), .fault(fault),
    .smp_valid(smp_valid), .smp_data(smp_data), .set_wr(set_wr),
    .set_sel(set_sel), .set_ch(set_ch), .set_val(set_val),
    .valve_on(valve_on), .stream(stream), .manual_mode(manual_mode),
    .dwell(dwell), .conc(conc), .conc_upd(conc_upd),
    .relay_on(relay_on), .flow_target(flow_target),
    .fac_pending(fac_pending), .fac_done(fac_done), .set_ack(set_ack),
    .set_err(set_err), .nv_save(nv_save));
  ssq_manifold i_ssq_manifold (.clk(clk), .go(go), .dwell(dwell),
    .smp_valid(smp_valid), .smp_data(smp_data));
  task end_of_test;
    if (err_total == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic pulse(ref logic p);
    p = 1'b1;
    @(negedge clk);
    p = 1'b0;
  endtask
  task wr(input logic [3:0] sel, input logic [2:0] ch,
      input logic [15:0] v, input logic ok);
    set_sel = sel;
    set_ch = ch;
    set_val = v;
    pulse(set_wr);
    chk("ack", set_ack, ok);
    chk("err", set_err, !ok);
    chk("save", nv_save, ok);
    @(negedge clk);
  endtask
  task wait_sw;
    logic [2:0] s0;
    s0 = stream;
    repeat (7000) if (stream === s0) @(negedge clk);
  endtask
  // ----------------------------------------------------------------
  // averaging model
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (cyc == 95000) begin
      err_total++;
      end_of_test();
    end
    if (rst_n && smp_valid && !dwell) begin
      q.push_back(smp_data);
      if (q.size() > len) void'(q.pop_front());
    end
  end
  always @(negedge clk) begin
    if (!rst_n) begin
      q = {};
      last = '{default: 0};
    end else begin
      if (stream !== pv_s || (dwell && !pv_d)) begin
        q = {};
        chk("held", conc, 16'(last[stream]));
      end
      if (conc_upd) begin
        s = 0;
        foreach (q[i]) s += q[i];
        chk("avg", conc, 16'(s / q.size()));
        last[stream] = s / q.size();
      end
    end
    pv_s = stream;
    pv_d = dwell;
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk("mode", manual_mode, 1'b0);
    chk("valve", valve_on, 6'h01);
    chk("flow", flow_target, 10'h320);
    chk("relay", relay_on, 1'b0);
    wr(ssq_pkg::SEL_PURGE, 3'h0, 16'h0005, 1'b1);
    wr(ssq_pkg::SEL_PURGE, 3'h0, 16'h01c3, 1'b0);
    wr(ssq_pkg::SEL_FLOW, 3'h0, 16'h0352, 1'b1);
    wr(ssq_pkg::SEL_FLOW, 3'h0, 16'h0385, 1'b0);
    wr(ssq_pkg::SEL_FLOW, 3'h0, 16'h02bb, 1'b0);
    wr(ssq_pkg::SEL_TOTAL, 3'h0, 16'h0002, 1'b0);
    wr(ssq_pkg::SEL_TOTAL, 3'h0, 16'h0003, 1'b1);
    wr(ssq_pkg::SEL_AVG, 3'h0, 16'h0000, 1'b0);
    wr(ssq_pkg::SEL_AVG, 3'h0, 16'h0065, 1'b0);
    wr(ssq_pkg::SEL_AVG, 3'h0, 16'h0003, 1'b1);
    wr(ssq_pkg::SEL_VISIT, 3'h6, 16'h0258, 1'b0);
    wr(ssq_pkg::SEL_VISIT, 3'h1, 16'h0257, 1'b0);
    wr(ssq_pkg::SEL_ACTIVE, 3'h1, 16'h0000, 1'b1);
    wr(4'hf, 3'h0, 16'h0000, 1'b0);
    repeat (7000) if (dwell === 1'b1) @(negedge clk);
    go = 1'b1;
    repeat (60) @(negedge clk);
    go = 1'b0;
    repeat (8) @(negedge clk);
    // pending count of 3 not applied yet
    pulse(manual_req);
    chk("mode", manual_mode, 1'b1);
    pulse(key_up);
    chk("stream", stream, 3'h0);
    pulse(key_back);
    chk("mode", manual_mode, 1'b0);
    len = 3;
    pulse(reboot);
    pulse(manual_req);
    pulse(key_up);
    chk("stream", stream, 3'h1);
    pulse(key_down);
    chk("stream", stream, 3'h2);
    chk("valve", valve_on, 6'h04);
    pulse(key_back);
    wait_sw();
    chk("stream", stream, 3'h0);
    t0 = cyc;
    repeat (7000) if (dwell === 1'b1) @(negedge clk);
    chk("purge", 16'(cyc - t0), 16'h0019);
    go = 1'b1;
    repeat (100) @(negedge clk);
    go = 1'b0;
    wait_sw();
    chk("visit", 16'(cyc - t0), 16'h0bb8);
    chk("stream", stream, 3'h2);
    wr(ssq_pkg::SEL_ACTIVE, 3'h0, 16'h0000, 1'b1);
    wr(ssq_pkg::SEL_ACTIVE, 3'h2, 16'h0000, 1'b1);
    repeat (3100) @(negedge clk);
    chk("stay", stream, 3'h2);
    fault = 1'b1;
    repeat (2) @(negedge clk);
    chk("relay", relay_on, 1'b1);
    wr(ssq_pkg::SEL_DEEN, 3'h0, 16'h0001, 1'b1);
    @(negedge clk);
    chk("relay", relay_on, 1'b0);
    fault = 1'b0;
    repeat (2) @(negedge clk);
    chk("relay", relay_on, 1'b1);
    pulse(fac_req);
    pulse(key_back);
    chk("pend", fac_pending, 1'b0);
    chk("flow", flow_target, 10'h352);
    pulse(fac_req);
    pulse(key_enter);
    chk("done", fac_done, 1'b1);
    chk("flow", flow_target, 10'h320);
    pulse(manual_req);
    t0 = cyc;
    repeat (61000) if (manual_mode === 1'b1) @(negedge clk);
    chk("tmo", cyc - t0 >= 29990 && cyc - t0 <= 30010, 1'b1);
    // timeout off keeps manual past the limit
    pulse(manual_req);
    wr(ssq_pkg::SEL_HOLD, 3'h0, 16'h0000, 1'b1);
    repeat (30100) @(negedge clk);
    chk("hold", manual_mode, 1'b1);
    wr(ssq_pkg::SEL_HOLD, 3'h0, 16'h0001, 1'b1);
    repeat (8) if (manual_mode === 1'b1) @(negedge clk);
    chk("tmo", manual_mode, 1'b0);
    end_of_test();
  end
endmodule
`default_nettype wire
